// [usp_consts.vh]
// Constants for the serial port power, loopback, address-wait and break logic.
// How it works
// R1 - Synchronous shift rate is baud clock divided by two
// R2 - Power-save entry sets tx empty, clears status
// R3 - Power-save entry fills tx shift register with ones
// R4 - Start bit on receive pin ends power save
// R5 - Software enables receive pin as wake source
// R6 - Software selects falling edge wake trigger
// R7 - Halt wake holds execution 256 idle timer cycles
// R8 - Both length bits set loop tx into rx
// R9 - Loopback uses nine-bit frame, no parity
// R10 - Software sets address wait with nine-bit frame
// R11 - Ninth bit one means address, zero data
// R12 - Address wait discards data until address arrives
// R13 - Accepted address clears address wait bit
// R14 - Software re-arms or leaves address wait bit
// R15 - Transmitter unaffected; ninth bits via control bits
// R16 - Bit access to rx status clears errors
// R17 - Break bit forces transmit pin low
// R18 - Length bits 0 then 1 select nine bits
// R19 - Rx interrupt pends while full and enabled
// R20 - Wake edge latched even with clock stopped
`ifndef USP_CONSTS_VH
`define USP_CONSTS_VH
`define USP_ADDR_W        3
`define USP_REG_CTRL      3'h0
`define USP_REG_RXSTAT    3'h1
`define USP_REG_IRQCTL    3'h2
`define USP_REG_TXBUF     3'h3
`define USP_REG_RXBUF     3'h4
`define USP_REG_BAUD      3'h5
`define USP_REG_WAKE      3'h6
`define USP_REG_PWR       3'h7
// Control register fields.
`define USP_CTRL_TX_NINTH_BIT    1
`define USP_CTRL_CHAR_LEN_SEL0     2
`define USP_CTRL_CHAR_LEN_SEL1     3
`define USP_CTRL_SYNC     4
`define USP_CTRL_TWOSTOP  5
`define USP_CTRL_TX_BUFFER_EMPTY_FLAG     7
// Receive status fields.
`define USP_RX_RX_NINTH_BIT      0
`define USP_RX_FERR       1
`define USP_RX_OERR       2
`define USP_RX_ADDRESS_WAIT_BIT       3
`define USP_RX_RX_BUFFER_FULL_FLAG       4
`define USP_RX_BITOP      7
// Interrupt control fields.
`define USP_IRQ_ERI       0
`define USP_IRQ_ETI       1
`define USP_IRQ_BRK       2
// Wake register fields and power commands.
`define USP_WAKE_EN       3
`define USP_WAKE_EDG      3
`define USP_PWR_HALT      0
`define USP_PWR_IDLE      1
// Timing.
`define USP_ASYNC_DIV     5'd16
`define USP_SYNC_DIV      5'd2
`define USP_OSC_DELAY     9'd256
`define USP_FRAME_BITS    4'd9
`endif

// [usp_wake_edge.v]
// Falling-edge wake detector on the receive pin that works with the core clock stopped.
`timescale 1ns/100ps
module usp_wake_edge (
  // Clocking.
  input  wire clk_in,
  input  wire reset_n_in,
  // Pin and control.
  input  wire pin_in,
  input  wire armed_in,
  input  wire clear_in,
  // Request.
  output reg  wake_out
);
  reg       edge_seen;
  reg [2:0] sync;

  // The pin itself clocks the latch, so a start bit is caught in halt. [R20]
  always @(negedge pin_in or negedge reset_n_in or posedge clear_in) begin
    if (!reset_n_in)
      edge_seen <= 1'b0;
    else if (clear_in)
      edge_seen <= 1'b0;
    else if (armed_in)
      edge_seen <= 1'b1;
  end

  // Three stages bring the latch into the core domain; second and third agree. [R20]
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync     <= 3'h0;
      wake_out <= 1'b0;
    end else begin
      sync <= {sync[1:0], edge_seen};
      if (sync[1] == sync[2])
        wake_out <= sync[2];
    end
  end
endmodule

// [usp_serial_port.v]
// Serial port with power-save reinit, loopback, address-wait mode and break.
`timescale 1ns/100ps
`include "usp_consts.vh"
module usp_serial_port (
  // Clock and reset.
  input  wire       clk_in,
  input  wire       reset_n_in,
  // Register port.
  input  wire [2:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  // Serial pins.
  input  wire       rx_data_pin_in,
  output reg        tx_data_pin_out,
  // Status to the core.
  output reg        rx_irq_out,
  output reg        sleeping_out,
  output reg        exec_hold_out
);
  // Register state.
  reg [7:0] serial_control_reg;
  reg       rx_ninth_bit;
  reg       rx_frame_err;
  reg       rx_overrun_err;
  reg       address_wait_bit;
  reg       rx_buffer_full_flag;
  reg       tx_buffer_empty_flag;
  reg [2:0] serial_irq_control_reg;
  reg [7:0] tx_holding_buffer;
  reg [7:0] rx_holding_buffer;
  reg [7:0] baud_div;
  reg [7:0] wakeup_enable_reg;
  reg [7:0] wakeup_edge_reg;
  // Shift engine state.
  reg [10:0] tx_shift_register;
  reg [3:0]  tx_count;
  reg        tx_busy;
  reg [8:0]  rx_shift_register;
  reg [3:0]  rx_count;
  reg        rx_busy;
  reg [3:0]  rx_phase;
  // Clocking and power.
  reg [7:0]  baud_cnt;
  reg [4:0]  sub_cnt;
  reg [2:0]  rx_sync;
  reg        rx_line;
  reg        halted;
  reg [8:0]  idle_timer;
  reg        osc_wait;
  wire       wake_req;

  wire char_len_sel0     = serial_control_reg[`USP_CTRL_CHAR_LEN_SEL0];
  wire char_len_sel1     = serial_control_reg[`USP_CTRL_CHAR_LEN_SEL1];
  wire loopback = char_len_sel0 & char_len_sel1;                       // [R8]
  wire nine_bit = char_len_sel1;                              // [R9] [R18]
  wire tx_ser   = tx_shift_register[0];
  wire wake_armed = sleeping_out & wakeup_enable_reg[`USP_WAKE_EN] & wakeup_edge_reg[`USP_WAKE_EDG];
  wire enter_sleep = wr_in && (addr_in == `USP_REG_PWR) && !sleeping_out;
  wire [4:0] shift_div = serial_control_reg[`USP_CTRL_SYNC] ? `USP_SYNC_DIV : `USP_ASYNC_DIV;

  // Number of data bits after the start bit (eight or nine), used by both directions.
  function [3:0] usp_data_bits;
    input nine;
    begin
      usp_data_bits = nine ? `USP_FRAME_BITS : 4'd8;
    end
  endfunction

  usp_wake_edge u_wake (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .pin_in     (rx_data_pin_in),
    .armed_in   (wake_armed),
    .clear_in   (!sleeping_out),
    .wake_out   (wake_req)
  );

  // Receive pin passes three flops; loopback bypasses the pin entirely.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_sync <= 3'h7;
      rx_line <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], rx_data_pin_in};
      if (rx_sync[1] == rx_sync[2])
        rx_line <= rx_sync[2];
    end
  end

  wire rx_in = loopback ? tx_ser : rx_line;          // [R8]

  // Baud divisor gives a 16x tick; the shift tick divides by 16 or 2.
  wire baud_tick  = (baud_cnt == 8'h00);
  wire shift_tick = baud_tick && (sub_cnt == 5'h00);
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      baud_cnt <= 8'h00;
      sub_cnt  <= 5'h00;
    end else if (sleeping_out) begin
      baud_cnt <= 8'h00;
      sub_cnt  <= 5'h00;
    end else begin
      baud_cnt <= baud_tick ? baud_div : baud_cnt - 8'h01;
      if (baud_tick)
        sub_cnt <= (sub_cnt == 5'h00) ? shift_div - 5'h01 : sub_cnt - 5'h01;   // [R1]
    end
  end

  // Power control: sleep on command, wake on start bit, then the oscillator delay after halt.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sleeping_out  <= 1'b0;
      halted        <= 1'b0;
      osc_wait      <= 1'b0;
      idle_timer    <= 9'h000;
      exec_hold_out <= 1'b0;
    end else begin
      if (enter_sleep) begin
        sleeping_out  <= 1'b1;
        halted        <= wdata_in[`USP_PWR_HALT];
        exec_hold_out <= 1'b1;
      end else if (sleeping_out && wake_req) begin
        sleeping_out <= 1'b0;                                   // [R4]
        osc_wait     <= halted;
        idle_timer   <= `USP_OSC_DELAY - 9'h001;
        exec_hold_out <= halted;                                // [R7]
      end else if (osc_wait) begin
        if (idle_timer == 9'h000) begin
          osc_wait      <= 1'b0;
          exec_hold_out <= 1'b0;                                // [R7]
        end else
          idle_timer <= idle_timer - 9'h001;
      end
    end
  end

  // Transmitter: break overrides the shift output on the pin.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_shift_register <= 11'h7FF;
      tx_count          <= 4'h0;
      tx_busy           <= 1'b0;
      tx_data_pin_out   <= 1'b1;
    end else begin
      tx_data_pin_out <= serial_irq_control_reg[`USP_IRQ_BRK] ? 1'b0 : tx_ser;   // [R17]
      if (enter_sleep) begin
        tx_shift_register <= 11'h7FF;                                          // [R3]
        tx_busy           <= 1'b0;
        tx_count          <= 4'h0;
      end else if (!tx_busy && !tx_buffer_empty_flag && shift_tick) begin
        // Ninth bit comes from the control register regardless of address mode. [R15]
        tx_shift_register <= nine_bit ?
          {1'b1, serial_control_reg[`USP_CTRL_TX_NINTH_BIT], tx_holding_buffer, 1'b0} :
          {2'b11, tx_holding_buffer, 1'b0};
        tx_count <= usp_data_bits(nine_bit) + (serial_control_reg[`USP_CTRL_TWOSTOP] ? 4'd2 : 4'd1);
        tx_busy  <= 1'b1;
      end else if (tx_busy && shift_tick) begin
        tx_shift_register <= {1'b1, tx_shift_register[10:1]};
        tx_count          <= tx_count - 4'h1;
        if (tx_count == 4'h0)
          tx_busy <= 1'b0;
      end
    end
  end

  // Receiver: sample mid-bit when asynchronous, every tick when synchronous.
  wire rx_sample = serial_control_reg[`USP_CTRL_SYNC] ? shift_tick : (baud_tick && rx_phase == 4'h0);
  wire rx_done   = rx_busy && rx_sample && (rx_count == 4'h0);
  wire rx_is_addr = nine_bit ? rx_shift_register[8] : 1'b0;               // [R11]
  wire rx_accept = rx_done && rx_in && (!address_wait_bit || rx_is_addr);  // [R12]
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_shift_register <= 9'h000;
      rx_count          <= 4'h0;
      rx_busy           <= 1'b0;
      rx_phase          <= 4'h0;
    end else if (enter_sleep) begin
      rx_busy <= 1'b0;                                  // [R3]
    end else if (!rx_busy) begin
      // The first sample lands mid start bit in async mode, or on the next shift tick in sync mode.
      // The start bit is shifted in too and falls off the end, so both modes share one counter.
      if (!rx_in && baud_tick) begin
        rx_busy  <= 1'b1;
        rx_phase <= 4'h7;
        rx_count <= usp_data_bits(nine_bit) + 4'h1;
      end
    end else if (baud_tick) begin
      rx_phase <= rx_phase - 4'h1;
      if (rx_sample) begin
        if (rx_count == 4'h0)
          rx_busy <= 1'b0;
        else begin
          rx_shift_register <= nine_bit ? {rx_in, rx_shift_register[8:1]}
                                        : {1'b0, rx_in, rx_shift_register[7:1]};
          rx_count <= rx_count - 4'h1;
        end
      end
    end
  end

  // Register writes and hardware-owned flags; receive sets win over clears, a tx buffer write over the load, sleep entry over all.
  wire wr_ctrl = wr_in && addr_in == `USP_REG_CTRL;
  wire wr_rxs  = wr_in && addr_in == `USP_REG_RXSTAT;
  wire rd_rxb  = rd_in && addr_in == `USP_REG_RXBUF;
  wire tx_load = !tx_busy && !tx_buffer_empty_flag && shift_tick && !enter_sleep;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_control_reg     <= 8'h00;
      serial_irq_control_reg <= 3'h0;
      tx_holding_buffer      <= 8'h00;
      rx_holding_buffer      <= 8'h00;
      baud_div               <= 8'h00;
      wakeup_enable_reg      <= 8'h00;
      wakeup_edge_reg        <= 8'h00;
      rx_ninth_bit           <= 1'b0;
      rx_frame_err           <= 1'b0;
      rx_overrun_err         <= 1'b0;
      address_wait_bit       <= 1'b0;
      rx_buffer_full_flag    <= 1'b0;
      tx_buffer_empty_flag   <= 1'b1;
      rx_irq_out             <= 1'b0;
    end else begin
      if (wr_ctrl)
        serial_control_reg <= {1'b0, wdata_in[6:0]};
      if (wr_in && addr_in == `USP_REG_IRQCTL)
        serial_irq_control_reg <= wdata_in[2:0];
      if (wr_in && addr_in == `USP_REG_BAUD)
        baud_div <= wdata_in;
      if (wr_in && addr_in == `USP_REG_WAKE) begin
        wakeup_enable_reg <= wdata_in;                 // [R5]
        wakeup_edge_reg   <= wdata_in;                 // [R6]
      end
      // Address-wait bit is read/write; software may re-arm it. [R10] [R14]
      if (wr_rxs)
        address_wait_bit <= wdata_in[`USP_RX_ADDRESS_WAIT_BIT];
      // A bit operation on receive status wipes the error flags. [R16]
      if (wr_rxs && wdata_in[`USP_RX_BITOP]) begin
        rx_frame_err   <= 1'b0;
        rx_overrun_err <= 1'b0;
      end
      if (wr_in && addr_in == `USP_REG_TXBUF) begin
        tx_holding_buffer    <= wdata_in;
        tx_buffer_empty_flag <= 1'b0;
      end else if (tx_load)
        tx_buffer_empty_flag <= 1'b1;
      if (rd_rxb)
        rx_buffer_full_flag <= 1'b0;                   // [R19]
      if (rx_done && !rx_in)
        rx_frame_err <= 1'b1;
      if (rx_accept) begin
        rx_holding_buffer   <= rx_shift_register[7:0];
        rx_ninth_bit        <= rx_shift_register[8];   // [R15]
        rx_buffer_full_flag <= 1'b1;                   // [R12]
        if (rx_buffer_full_flag && !rd_rxb)
          rx_overrun_err <= 1'b1;
        if (address_wait_bit)
          address_wait_bit <= 1'b0;                    // [R13]
      end
      // Power-save entry: tx empty set, read-only bits cleared, r/w bits kept. [R2]
      if (enter_sleep) begin
        tx_buffer_empty_flag <= 1'b1;
        rx_ninth_bit         <= 1'b0;
        rx_frame_err         <= 1'b0;
        rx_overrun_err       <= 1'b0;
        rx_buffer_full_flag  <= 1'b0;
      end
      rx_irq_out <= rx_buffer_full_flag & serial_irq_control_reg[`USP_IRQ_ERI];   // [R19]
    end
  end

  // Read data one cycle after the strobe; zero otherwise.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      rdata_out <= 8'h00;
    else if (!rd_in)
      rdata_out <= 8'h00;
    else begin
      case (addr_in)
        `USP_REG_CTRL:   rdata_out <= {tx_buffer_empty_flag, serial_control_reg[6:0]};
        `USP_REG_RXSTAT: rdata_out <= {3'h0, rx_buffer_full_flag, address_wait_bit,
                                       rx_overrun_err, rx_frame_err, rx_ninth_bit};
        `USP_REG_IRQCTL: rdata_out <= {5'h00, serial_irq_control_reg};
        `USP_REG_TXBUF:  rdata_out <= tx_holding_buffer;
        `USP_REG_RXBUF:  rdata_out <= rx_holding_buffer;
        `USP_REG_BAUD:   rdata_out <= baud_div;
        `USP_REG_WAKE:   rdata_out <= wakeup_enable_reg & wakeup_edge_reg;
        `USP_REG_PWR:    rdata_out <= {6'h00, exec_hold_out, sleeping_out};
        default:         rdata_out <= 8'h00;
      endcase
    end
  end
endmodule

// [usp_peer.sv]
// Remote station model that drives nine-bit asynchronous frames onto the receive line.
`timescale 1ns/100ps
module usp_peer (
  // Clock.
  input  wire clk_in,
  // Serial line.
  output reg  line_out
);
  integer i;

  // The line rests at the marking level between frames, as a real idle line does.
  initial line_out = 1'b1;

  // Start bit, eight data bits LSB first, the ninth bit, one stop bit; no parity.
  // A set ninth bit marks the character as a station address.
  task send(input [8:0] d, input integer per);
    reg [10:0] f;
    begin
      f = {1'b1, d, 1'b0};
      for (i = 0; i < 11; i = i + 1) begin
        @(posedge clk_in);
        line_out <= f[i];
        repeat (per - 1) @(posedge clk_in);
      end
    end
  endtask
endmodule

// [usp_serial_port_chk.sv]
// Property checker for the serial port break, power-save, wake and interrupt behaviour.
`timescale 1ns/100ps
module usp_serial_port_chk (
  // Clock and reset.
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  // Register port.
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  // Pins and status.
  input wire logic       rx_data_pin_in,
  input wire logic       tx_data_pin_out,
  input wire logic       rx_irq_out,
  input wire logic       sleeping_out,
  input wire logic       exec_hold_out
);
  logic       brk_on;
  logic       halt_sel;
  logic       wake_armed;
  logic [8:0] hold_cnt;
  logic [3:0] high_cnt;

  // Only ports are visible, so control bits are shadowed from the writes seen.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      brk_on     <= 1'b0;
      halt_sel   <= 1'b0;
      wake_armed <= 1'b0;
      hold_cnt   <= 9'h000;
      high_cnt   <= 4'h0;
    end else begin
      if (wr_in && addr_in == 3'h2) brk_on <= wdata_in[2];
      if (wr_in && addr_in == 3'h7) halt_sel <= wdata_in[0];
      if (wr_in && addr_in == 3'h6) wake_armed <= wdata_in[3];
      // Both counters saturate so a long quiet spell cannot wrap them.
      hold_cnt <= (exec_hold_out && !sleeping_out) ? hold_cnt + {8'h00, hold_cnt != 9'h1FF} : 9'h000;
      high_cnt <= rx_data_pin_in ? high_cnt + {3'h0, high_cnt != 4'hF} : 4'h0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_brk_held;
    brk_on ##1 brk_on;
  endsequence
  sequence s_slept;
    sleeping_out ##1 sleeping_out;
  endsequence

  a_break_low: assert property (s_brk_held |-> !tx_data_pin_out)
    else $error("tx pin not low during break");
  a_sleep_tx_idle: assert property (s_slept |-> tx_data_pin_out || brk_on)
    else $error("tx pin not high while asleep");
  a_sleep_entry: assert property (wr_in && addr_in == 3'h7 |-> ##[1:2] sleeping_out)
    else $error("power write did not enter sleep");
  a_sleep_holds: assert property (s_slept |-> exec_hold_out)
    else $error("core not held while asleep");
  a_wake_fast: assert property (sleeping_out && wake_armed && $fell(rx_data_pin_in) |-> ##[1:8] !sleeping_out)
    else $error("start bit did not wake");
  a_no_stray_wake: assert property (sleeping_out && high_cnt == 4'hF |=> sleeping_out)
    else $error("woke without a falling edge");
  a_halt_wait: assert property ($fell(exec_hold_out) && halt_sel |-> hold_cnt >= 9'd250 && hold_cnt <= 9'd260)
    else $error("oscillator wait length wrong");
  a_idle_release: assert property ($fell(exec_hold_out) && !halt_sel |-> hold_cnt <= 9'd4)
    else $error("idle wake held the core too long");
  a_irq_read_clr: assert property (rd_in && addr_in == 3'h4 |-> ##2 !rx_irq_out)
    else $error("rx interrupt stayed after buffer read");
endmodule

// [usp_serial_port_bench.sv]
// Self-checking bench for the serial port power, loopback, address-wait and break logic.
`timescale 1ns/100ps
module usp_serial_port_bench;
  reg         clk_in     = 1'b0;
  reg         reset_n_in = 1'b0;
  reg  [2:0]  addr       = 3'h0;
  reg  [7:0]  wdata      = 8'h00;
  reg         wr_s       = 1'b0;
  reg         rd_s       = 1'b0;
  wire [7:0]  rdata;
  wire        rx_line;
  wire        tx_pin;
  wire        irq;
  wire        sleeping;
  wire        hold;
  integer     bad_count  = 0;
  integer     compares   = 0;
  integer     n;

  // 200 MHz clock.
  always #2.5 clk_in = ~clk_in;

  usp_serial_port i_usp_serial_port (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .rx_data_pin_in(rx_line),
    .tx_data_pin_out(tx_pin), .rx_irq_out(irq), .sleeping_out(sleeping), .exec_hold_out(hold));
  usp_peer i_usp_peer (.clk_in(clk_in), .line_out(rx_line));

  task chk(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk1(input got, input exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  // Register accesses hold each strobe for exactly one cycle.
  task wr(input [2:0] a, input [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk_in);
    wr_s  <= 1'b0;
  endtask
  task rd(input [2:0] a, input [7:0] m, input [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  // Bounded wait for the receive interrupt; the bound separates divide-by-2 from divide-by-16.
  task wait_irq(input integer lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk_in);
      #1;
      n = n + 1;
    end
    chk1(irq, 1'b1);
  endtask
  task wait_wake;
    n = 0;
    while (sleeping !== 1'b0 && n < 200) begin
      @(posedge clk_in);
      #1;
      n = n + 1;
    end
    chk1(sleeping, 1'b0);
  endtask
  task give_verdict;
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // The whole sequence needs about 2000 cycles; this cuts a hang short.
  initial begin
    repeat (30000) @(posedge clk_in);
    bad_count = bad_count + 1;
    give_verdict;
  end

  initial begin
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(3'h0, 8'h80, 8'h80);
    wr(3'h5, 8'h00);
    wr(3'h2, 8'h01);
    wr(3'h0, 8'h0E);
    wr(3'h3, 8'hA5);
    wait_irq(400);
    rd(3'h1, 8'h11, 8'h11);
    rd(3'h4, 8'hFF, 8'hA5);
    repeat (2) @(posedge clk_in);
    #1 chk1(irq, 1'b0);
    wr(3'h0, 8'h1C);
    wr(3'h3, 8'h3C);
    wait_irq(60);
    rd(3'h1, 8'h01, 8'h00);
    rd(3'h4, 8'hFF, 8'h3C);
    wr(3'h0, 8'h0A);
    wr(3'h2, 8'h05);
    repeat (3) @(posedge clk_in);
    #1 chk1(tx_pin, 1'b0);
    wr(3'h2, 8'h01);
    repeat (3) @(posedge clk_in);
    #1 chk1(tx_pin, 1'b1);
    // A data character is dropped while waiting for an address.
    wr(3'h1, 8'h08);
    i_usp_peer.send(9'h055, 16);
    repeat (40) @(posedge clk_in);
    #1 chk1(irq, 1'b0);
    i_usp_peer.send(9'h142, 16);
    wait_irq(60);
    rd(3'h1, 8'h19, 8'h11);
    i_usp_peer.send(9'h017, 16);
    repeat (40) @(posedge clk_in);
    rd(3'h1, 8'h14, 8'h14);
    wr(3'h1, 8'h80);
    rd(3'h1, 8'h06, 8'h00);
    rd(3'h4, 8'h00, 8'h00);
    wr(3'h1, 8'h08);
    i_usp_peer.send(9'h033, 16);
    repeat (40) @(posedge clk_in);
    #1 chk1(irq, 1'b0);
    i_usp_peer.send(9'h1AB, 16);
    wait_irq(60);
    // Halt with a full receive buffer; the flag must be cleared on entry.
    wr(3'h6, 8'h08);
    rd(3'h6, 8'h08, 8'h08);
    wr(3'h7, 8'h01);
    repeat (3) @(posedge clk_in);
    rd(3'h7, 8'h03, 8'h03);
    rd(3'h1, 8'h17, 8'h00);
    rd(3'h0, 8'hBE, 8'h8A);
    chk1(tx_pin, 1'b1);
    fork
      i_usp_peer.send(9'h0C3, 16);
    join_none
    wait_wake;
    n = 0;
    while (hold !== 1'b0 && n < 400) begin
      @(posedge clk_in);
      #1;
      n = n + 1;
    end
    chk1(n >= 253 && n <= 259, 1'b1);
    repeat (20) @(posedge clk_in);
    rd(3'h4, 8'h00, 8'h00);
    // Idle wake releases the core without the oscillator wait.
    wr(3'h7, 8'h00);
    repeat (3) @(posedge clk_in);
    fork
      i_usp_peer.send(9'h05A, 16);
    join_none
    wait_wake;
    repeat (4) @(posedge clk_in);
    #1 chk1(hold, 1'b0);
    repeat (200) @(posedge clk_in);
    give_verdict;
  end
endmodule

bind usp_serial_port usp_serial_port_chk i_usp_serial_port_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .rx_data_pin_in(rx_data_pin_in), .tx_data_pin_out(tx_data_pin_out), .rx_irq_out(rx_irq_out),
  .sleeping_out(sleeping_out), .exec_hold_out(exec_hold_out));
